// >>> core/bank_remap.sv
// Purpose: Routes logical bank strobes to physical bank strobes
// Assumes: Map is four 2-bit fields, one per physical bank
// Notes: Duplicate fields are rejected and identity is used instead
`timescale 1ns/1ps
module bank_remap (
  input wire logic [7:0] i_map,
  input wire dram_map_pkg::strobes_t i_logical,
  output logic [3:0] o_row,
  output logic [3:0] o_col
);
  // A map is legal only if every logical bank appears once
  wire [3:0] seen;
  wire legal;
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_seen
      assign seen[g] = (i_map[1:0] == 2'(g)) | (i_map[3:2] == 2'(g)) |
                       (i_map[5:4] == 2'(g)) | (i_map[7:6] == 2'(g));
    end
  endgenerate
  assign legal = &seen;

  // Physical bank p takes the strobes of the logical bank in field p
  generate
    for (g = 0; g < 4; g++) begin : g_route
      wire [1:0] sel;
      assign sel = legal ? i_map[2*g+1:2*g] : 2'(g);
      assign o_row[g] = i_logical.row[sel]; // [R4] [R23]
      assign o_col[g] = i_logical.col[sel]; // [R4] [R23]
    end
  endgenerate
endmodule : bank_remap

// >>> core/dram_map_defines.svh
// Purpose: Constants for the memory map and refresh control block
// Assumes: Included by bare name
// Notes: Offsets and counts shared by the control module and the bench
`ifndef DRAM_MAP_DEFINES_SVH
`define DRAM_MAP_DEFINES_SVH
`define CLK_PERIOD_NS 10
`define REFRESH_NORM_NS 15000
`define REFRESH_NORM_CYC ((`REFRESH_NORM_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STAGGER_CYC 8'h04
`define RAS_PULSE_CYC 8'h03
`define PAGE_SET_SIZE 36
`define BACKFILL_REGS 24
`define FRAME_REGS 12
`define REG_CTRL 8'h00
`define REG_REMAP 8'h01
`define REG_OB_DIV 8'h02
`define REG_SB_DIV 8'h03
`define REG_DRAM_LIMIT 8'h04
`define REG_SHADOW_LO 8'h05
`define REG_SHADOW_HI 8'h06
`define REG_SHADOW_TOP 8'h08
`define REG_STATUS 8'h07
`define REG_PAGE_BASE 8'h40
`define CTRL_COUPLED 0
`define CTRL_EMS_EN 1
`define CTRL_FRAME_ALT 2
`define CTRL_ALT_SET 3
`define CTRL_ROM16 4
`define CTRL_RESET 8'h11
`define REMAP_RESET 8'hE4
`define DRAM_LIMIT_RESET 8'h00
`define PAGE_EN_BIT 12
`endif

// >>> core/dram_map_pkg.sv
// Purpose: Types for the memory map and refresh control block
// Assumes: Nothing beyond the defines header
// Notes: Cycle classes and carried bundles
package dram_map_pkg;
  typedef enum logic [2:0] {
    CYC_INTA = 3'b000,
    CYC_IO_RD = 3'b001,
    CYC_IO_WR = 3'b010,
    CYC_CODE_RD = 3'b011,
    CYC_HALT = 3'b100,
    CYC_MEM_RD = 3'b101,
    CYC_MEM_WR = 3'b110,
    CYC_NONE = 3'b111
  } cycle_t;

  typedef enum logic [1:0] {
    SHD_ROM = 2'b00,
    SHD_DRAM = 2'b01,
    SHD_RD_DRAM = 2'b10,
    SHD_WR_DRAM = 2'b11
  } shadow_t;

  typedef enum logic [1:0] {
    TGT_DRAM = 2'b00,
    TGT_SLOT = 2'b01,
    TGT_BIOS = 2'b10,
    TGT_NPX = 2'b11
  } target_t;

  typedef struct packed {
    logic [3:0] row;
    logic [3:0] col;
  } strobes_t;

  typedef struct packed {
    cycle_t cyc;
    target_t tgt;
    logic npx_b;
    logic [25:2] phys;
    logic [3:0] lanes;
  } decode_t;
endpackage : dram_map_pkg

// >>> core/dram_memory_map_control.sv
// Purpose: Address decode, page translation, shadow control, bank remap and refresh scheduling
// Assumes: Synchronous inputs on i_clk; configuration over a plain register port
// Notes: Read data is valid the cycle after the read strobe
// Function
// R1 - Refresh runs coupled (both together) or decoupled (independent timers).
// R2 - Decoupled mode has separate programmable on-board and slot-bus intervals, slower allowed.
// R3 - Refresh row strobes are staggered across banks, never all at once.
// R4 - Any logical bank strobe pair routes to any of four physical outputs.
// R5 - Row strobe outputs active low; column and byte lane outputs active high.
// R6 - Two page mapping sets, standard and alternate, of 36 registers each.
// R7 - Backfill down to 256K, 24 registers per set translate that space.
// R8 - Twelve frame registers cover C0000h to EFFFFh by default.
// R9 - A control bit moves frame registers to A0000-BFFFFh and D0000h-DFFFFh.
// R10 - Each mapping register translates anywhere in 64 Mbyte on-board DRAM.
// R11 - Page translation can be disabled; board DRAM limited down to 256K.
// R12 - Shadow control chosen per 16K segment from 640K to 1M.
// R13 - Shadow settings: ROM both, DRAM both, DRAM read only, DRAM write only.
// R14 - Enabled page translation overrides the segment shadow setting.
// R15 - Address bit 26 decoded so accesses above 64 Mbyte never alias.
// R16 - Address bits 31 and 29 separate upper BIOS and two coprocessor types.
// R17 - While hold acknowledge is high, bits 31, 29 and 26 are forced low.
// R18 - Active-low processor byte enables select individual byte lanes.
// R19 - Write/read indicator decoded with other cycle inputs to classify cycles.
// R20 - BIOS ROM may be 8-bit or 16-bit wide.
// R21 - Reset defaults allow booting at full speed with reduced capability.
// R22 - Falling address strobe with valid command starts a bus cycle.
// R23 - Bank remap is a permutation applied alike to all strobes.
`timescale 1ns/1ps
`include "dram_map_defines.svh"
module dram_memory_map_control (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [15:0] o_reg_rdata,
  input wire logic i_a31,
  input wire logic i_a29,
  input wire logic i_a26,
  input wire logic [25:2] i_addr,
  input wire logic [3:0] i_cpu_byte_enables_n,
  input wire logic i_w_r,
  input wire logic i_d_c,
  input wire logic i_m_io,
  input wire logic i_addr_strobe_n,
  input wire logic i_hold_ack_in,
  input wire logic [3:0] i_internal_row_strobe,
  input wire logic [3:0] i_internal_col_strobe,
  output logic [3:0] o_bank_row_strobe_out_n,
  output logic [3:0] o_bank_col_strobe_out,
  output logic [3:0] o_local_byte_lane_out,
  output logic o_cycle_start,
  output dram_map_pkg::decode_t o_decode,
  output logic o_slot_refresh_req,
  output logic o_rom16
);
  // Configuration state
  logic [7:0] ctrl_q;
  logic [7:0] remap_q;
  logic [15:0] ob_div_q;
  logic [15:0] sb_div_q;
  logic [7:0] limit_q;
  logic [15:0] shadow_lo_q;
  logic [15:0] shadow_hi_q;
  logic [15:0] shadow_top_q;
  logic [12:0] page_q [0:71];
  logic [15:0] rdata_q;
  logic ads_prev_q;
  dram_map_pkg::decode_t decode_q;

  // Refresh state
  logic [15:0] ob_cnt_q;
  logic [15:0] sb_cnt_q;
  logic [2:0] stag_bank_q;
  logic [7:0] stag_cnt_q;
  logic ob_pending_q;
  logic slot_req_q;
  logic [3:0] ref_row;

  // Control fields
  wire coupled = ctrl_q[`CTRL_COUPLED];
  wire ems_en = ctrl_q[`CTRL_EMS_EN];
  wire frame_alt = ctrl_q[`CTRL_FRAME_ALT];
  wire alt_set = ctrl_q[`CTRL_ALT_SET];

  // Register port decode
  wire wr_ctrl = i_reg_wr & (i_reg_addr == `REG_CTRL);
  wire wr_remap = i_reg_wr & (i_reg_addr == `REG_REMAP);
  wire wr_obdiv = i_reg_wr & (i_reg_addr == `REG_OB_DIV);
  wire wr_sbdiv = i_reg_wr & (i_reg_addr == `REG_SB_DIV);
  wire wr_limit = i_reg_wr & (i_reg_addr == `REG_DRAM_LIMIT);
  wire wr_shlo = i_reg_wr & (i_reg_addr == `REG_SHADOW_LO);
  wire wr_shhi = i_reg_wr & (i_reg_addr == `REG_SHADOW_HI);
  wire wr_shtop = i_reg_wr & (i_reg_addr == `REG_SHADOW_TOP);
  wire page_hit = (i_reg_addr >= `REG_PAGE_BASE) && (i_reg_addr < (`REG_PAGE_BASE + 8'd72));
  wire [7:0] page_idx = i_reg_addr - `REG_PAGE_BASE;
  wire [15:0] status_word = {8'h00, 1'b0, stag_bank_q, ob_pending_q, slot_req_q, 2'b00};

  // Read mux, unmapped offsets read zero
  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0000;
    if (page_hit) begin
      rd_mux = {3'b000, page_q[page_idx[6:0]]};
    end else begin
      unique case (i_reg_addr)
        `REG_CTRL: rd_mux = {8'h00, ctrl_q};
        `REG_REMAP: rd_mux = {8'h00, remap_q};
        `REG_OB_DIV: rd_mux = ob_div_q;
        `REG_SB_DIV: rd_mux = sb_div_q;
        `REG_DRAM_LIMIT: rd_mux = {8'h00, limit_q};
        `REG_SHADOW_LO: rd_mux = shadow_lo_q;
        `REG_SHADOW_HI: rd_mux = shadow_hi_q;
        `REG_SHADOW_TOP: rd_mux = shadow_top_q;
        `REG_STATUS: rd_mux = status_word;
        default: rd_mux = 16'h0000;
      endcase
    end
  end

  // Read data stands one cycle after the strobe only
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= i_reg_rd ? rd_mux : 16'h0000;
    end
  end
  assign o_reg_rdata = rdata_q;

  // Configuration registers, defaults boot with translation and shadow off
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_q <= `CTRL_RESET; // [R21]
      remap_q <= `REMAP_RESET; // [R21]
      ob_div_q <= 16'(`REFRESH_NORM_CYC); // [R21]
      sb_div_q <= 16'(`REFRESH_NORM_CYC);
      limit_q <= `DRAM_LIMIT_RESET;
      shadow_lo_q <= 16'h0000;
      shadow_hi_q <= 16'h0000;
      shadow_top_q <= 16'h0000;
    end else begin
      if (wr_ctrl) ctrl_q <= i_reg_wdata[7:0];
      if (wr_remap) remap_q <= i_reg_wdata[7:0];
      if (wr_obdiv) ob_div_q <= i_reg_wdata; // [R2]
      if (wr_sbdiv) sb_div_q <= i_reg_wdata; // [R2]
      if (wr_limit) limit_q <= i_reg_wdata[7:0]; // [R11]
      if (wr_shlo) shadow_lo_q <= i_reg_wdata; // [R12]
      if (wr_shhi) shadow_hi_q <= i_reg_wdata; // [R12]
      if (wr_shtop) shadow_top_q <= i_reg_wdata; // [R12]
    end
  end

  // Page mapping registers, two sets of 36, each 16K page number plus enable
  genvar g;
  generate
    for (g = 0; g < 72; g++) begin : g_page
      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          page_q[g] <= 13'h0000;
        end else if (i_reg_wr && page_hit && (page_idx == 8'(g))) begin
          page_q[g] <= i_reg_wdata[12:0]; // [R6] [R10]
        end
      end
    end
  endgenerate

  // Address qualifiers masked while a bus master holds the bus
  wire a31_eff = i_a31 & ~i_hold_ack_in; // [R17]
  wire a29_eff = i_a29 & ~i_hold_ack_in; // [R17]
  wire a26_eff = i_a26 & ~i_hold_ack_in; // [R17]

  // Cycle classification from write/read, data/code and memory/io
  dram_map_pkg::cycle_t cyc;
  always_comb begin
    unique case ({i_m_io, i_d_c, i_w_r}) // [R19]
      3'b000: cyc = dram_map_pkg::CYC_INTA;
      3'b001: cyc = dram_map_pkg::CYC_NONE;
      3'b010: cyc = dram_map_pkg::CYC_IO_RD;
      3'b011: cyc = dram_map_pkg::CYC_IO_WR;
      3'b100: cyc = dram_map_pkg::CYC_CODE_RD;
      3'b101: cyc = dram_map_pkg::CYC_HALT;
      3'b110: cyc = dram_map_pkg::CYC_MEM_RD;
      3'b111: cyc = dram_map_pkg::CYC_MEM_WR;
    endcase
  end

  // Cycle kinds that reach memory
  wire is_mem = (cyc == dram_map_pkg::CYC_MEM_RD) | (cyc == dram_map_pkg::CYC_MEM_WR) |
                (cyc == dram_map_pkg::CYC_CODE_RD);
  wire is_wr = (cyc == dram_map_pkg::CYC_MEM_WR);

  // Page window lookup: backfill 256K..640K, then frame pages
  wire [5:0] seg = i_addr[19:14];
  wire low_mb = ~a26_eff & (i_addr[25:20] == 6'h00);
  wire in_backfill = low_mb & (seg >= 6'd16) & (seg < 6'd40); // [R7]
  wire in_frame_def = low_mb & (seg >= 6'd48) & (seg < 6'd60); // [R8]
  wire in_frame_alt = low_mb & (((seg >= 6'd40) & (seg < 6'd48)) | ((seg >= 6'd52) & (seg < 6'd56))); // [R9]
  wire in_frame = frame_alt ? in_frame_alt : in_frame_def;
  wire [5:0] frame_slot = frame_alt ? ((seg < 6'd48) ? (seg - 6'd40) : (seg - 6'd44)) : (seg - 6'd48);
  wire [5:0] slot = in_backfill ? (seg - 6'd16) : (6'd24 + frame_slot);
  wire [6:0] set_idx = alt_set ? (7'd36 + {1'b0, slot}) : {1'b0, slot}; // [R6]
  wire [12:0] map_entry = page_q[set_idx];
  wire ems_hit = ems_en & (in_backfill | in_frame) & map_entry[`PAGE_EN_BIT]; // [R11]
  wire [25:2] ems_addr = {map_entry[11:0], i_addr[13:2]}; // [R10]

  // Shadow setting for segments 640K..1M, twenty-four 16K segments
  wire in_shadow = low_mb & (seg >= 6'd40); // [R12]
  wire [4:0] sh_idx = 5'(seg - 6'd40);
  wire [47:0] shadow_all = {shadow_top_q, shadow_hi_q, shadow_lo_q};
  wire [1:0] sh_bits = shadow_all[{sh_idx, 1'b0} +: 2];
  wire sh_dram = (sh_bits == dram_map_pkg::SHD_DRAM) |
                 ((sh_bits == dram_map_pkg::SHD_RD_DRAM) & ~is_wr) |
                 ((sh_bits == dram_map_pkg::SHD_WR_DRAM) & is_wr); // [R13]

  // Board DRAM limit in 256K steps; zero means full 64M
  wire [7:0] blk = i_addr[25:18];
  wire over_limit = (limit_q != 8'h00) & (blk >= limit_q); // [R11]

  // Target decision, upper address bits first, then translation, then shadow, then limit
  dram_map_pkg::target_t tgt;
  always_comb begin
    if (a31_eff) begin
      tgt = a29_eff ? dram_map_pkg::TGT_NPX : dram_map_pkg::TGT_BIOS; // [R16]
    end else if (a26_eff) begin
      tgt = dram_map_pkg::TGT_SLOT; // [R15]
    end else if (ems_hit) begin
      tgt = dram_map_pkg::TGT_DRAM; // [R14]
    end else if (in_shadow) begin
      tgt = sh_dram ? dram_map_pkg::TGT_DRAM : dram_map_pkg::TGT_SLOT; // [R13]
    end else if (over_limit) begin
      tgt = dram_map_pkg::TGT_SLOT;
    end else begin
      tgt = dram_map_pkg::TGT_DRAM;
    end
  end

  // Coprocessor type select
  wire npx_b = i_addr[25]; // Distinguishes the second coprocessor type [R16]

  // Assemble decode at the cycle start
  wire cycle_start = ads_prev_q & ~i_addr_strobe_n; // [R22]
  dram_map_pkg::decode_t dec_d;
  always_comb begin
    dec_d.cyc = cyc;
    dec_d.tgt = is_mem ? tgt : dram_map_pkg::TGT_SLOT;
    dec_d.npx_b = npx_b;
    dec_d.phys = ems_hit ? ems_addr : i_addr;
    dec_d.lanes = ~i_cpu_byte_enables_n; // [R18]
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ads_prev_q <= 1'b1;
      decode_q <= '0;
    end else begin
      ads_prev_q <= i_addr_strobe_n;
      if (cycle_start) decode_q <= dec_d; // [R22]
    end
  end

  // Decode and configuration outputs
  assign o_decode = decode_q;
  assign o_cycle_start = cycle_start;
  assign o_rom16 = ctrl_q[`CTRL_ROM16]; // [R20]

  // Interval timers; coupled mode drives both from the on-board timer
  wire ob_tick = (ob_cnt_q == 16'h0000);
  wire sb_tick = coupled ? ob_tick : (sb_cnt_q == 16'h0000); // [R1]
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ob_cnt_q <= 16'(`REFRESH_NORM_CYC);
      sb_cnt_q <= 16'(`REFRESH_NORM_CYC);
      slot_req_q <= 1'b0;
    end else begin
      ob_cnt_q <= ob_tick ? ob_div_q : ob_cnt_q - 16'h0001; // [R2]
      sb_cnt_q <= (sb_cnt_q == 16'h0000) ? sb_div_q : sb_cnt_q - 16'h0001; // [R2]
      slot_req_q <= sb_tick; // [R1]
    end
  end

  // Slot refresh request pin
  assign o_slot_refresh_req = slot_req_q;

  // Staggered refresh: banks strobed one after another
  wire stag_active = (stag_bank_q != 3'd4);
  wire stag_step = stag_active & (stag_cnt_q == `STAGGER_CYC - 8'h01);
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      stag_bank_q <= 3'd4;
      stag_cnt_q <= 8'h00;
      ob_pending_q <= 1'b0;
    end else begin
      if (ob_tick) begin
        ob_pending_q <= 1'b1; // Set wins over the start clear
      end else if (~stag_active & ob_pending_q) begin
        ob_pending_q <= 1'b0;
      end
      if (~stag_active & ob_pending_q) begin
        stag_bank_q <= 3'd0;
        stag_cnt_q <= 8'h00;
      end else if (stag_step) begin
        stag_bank_q <= stag_bank_q + 3'd1; // [R3]
        stag_cnt_q <= 8'h00;
      end else if (stag_active) begin
        stag_cnt_q <= stag_cnt_q + 8'h01;
      end
    end
  end

  // One bank's refresh row strobe at a time
  generate
    for (g = 0; g < 4; g++) begin : g_ref
      assign ref_row[g] = stag_active & (stag_bank_q[1:0] == 2'(g)) &
                            (stag_cnt_q < `RAS_PULSE_CYC); // [R3]
    end
  endgenerate

  // Remap logical strobes, refresh included, then drive pins
  dram_map_pkg::strobes_t logical;
  assign logical.row = i_internal_row_strobe | ref_row; // [R23]
  assign logical.col = i_internal_col_strobe;
  logic [3:0] phys_row;
  logic [3:0] phys_col;
  bank_remap u_remap (
    .i_map(remap_q),
    .i_logical(logical),
    .o_row(phys_row),
    .o_col(phys_col)
  );

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_bank_row_strobe_out_n <= 4'hF;
      o_bank_col_strobe_out <= 4'h0;
      o_local_byte_lane_out <= 4'h0;
    end else begin
      o_bank_row_strobe_out_n <= ~phys_row; // [R5]
      o_bank_col_strobe_out <= phys_col; // [R5]
      o_local_byte_lane_out <= ~i_cpu_byte_enables_n; // [R5] [R18]
    end
  end
endmodule : dram_memory_map_control

// >>> test/cpu_bus_model.sv
// Purpose: Processor bus model, one bus cycle per call
// Assumes: Called from the bench between rising edges
// Notes: Address and byte enable lines are inverted after the cycle so stale values never look valid
`timescale 1ns/1ps
module cpu_bus_model (
  input wire logic i_clk,
  output logic o_ads_n,
  output logic [2:0] o_hi,
  output logic [25:2] o_addr,
  output logic [3:0] o_be_n,
  output logic [2:0] o_mdw,
  output logic o_hold
);
  // Idle bus at time zero
  initial begin
    o_ads_n = 1'b1;
    o_hi = 3'h0;
    o_addr = 24'h000000;
    o_be_n = 4'hF;
    o_mdw = 3'h7;
    o_hold = 1'b0;
  end

  // Strobe for one cycle with address valid, then release the lines
  task automatic run(input logic [2:0] h, input logic [25:2] a, input logic [3:0] b, input logic [2:0] c,
    input logic hd);
    @(posedge i_clk);
    o_ads_n <= 1'b0;
    o_hi <= h;
    o_addr <= a;
    o_be_n <= b;
    o_mdw <= c;
    o_hold <= hd;
    @(posedge i_clk);
    o_ads_n <= 1'b1;
    @(posedge i_clk);
    o_addr <= ~a;
    o_be_n <= ~b;
    o_hold <= 1'b0;
  endtask : run
endmodule : cpu_bus_model

// >>> test/dram_map_check_sva.sv
// Purpose: Port-level checks for the memory map control block
// Assumes: One clock, asynchronous active high reset
// Notes: Bound to the top module below
`timescale 1ns/1ps
module dram_map_check (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_a31,
  input wire logic i_a29,
  input wire logic i_a26,
  input wire logic [25:2] i_addr,
  input wire logic [3:0] i_cpu_byte_enables_n,
  input wire logic i_w_r,
  input wire logic i_d_c,
  input wire logic i_m_io,
  input wire logic i_addr_strobe_n,
  input wire logic i_hold_ack_in,
  input wire logic [3:0] i_internal_row_strobe,
  input wire logic [3:0] i_internal_col_strobe,
  input wire logic [3:0] o_bank_row_strobe_out_n,
  input wire logic [3:0] o_bank_col_strobe_out,
  input wire logic [3:0] o_local_byte_lane_out,
  input wire logic o_cycle_start,
  input wire dram_map_pkg::decode_t o_decode,
  input wire logic o_slot_refresh_req
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // Strobes, lanes and refresh
  lane_follow_a: assert property (!$past(i_rst) |-> o_local_byte_lane_out == ~$past(i_cpu_byte_enables_n))
    else $error("byte lanes do not follow enables");
  col_count_a: assert property (!$past(i_rst)
    |-> $countones(o_bank_col_strobe_out) == $countones($past(i_internal_col_strobe)))
    else $error("column strobe count changed by remap");
  stagger_a: assert property (!$past(i_rst) && $past(i_internal_row_strobe) == 4'h0
    |-> $countones(~o_bank_row_strobe_out_n) <= 1)
    else $error("refresh row strobes overlap");
  slot_pulse_a: assert property (o_slot_refresh_req |=> !o_slot_refresh_req)
    else $error("slot refresh request longer than one cycle");
  // Cycle start and decode
  start_edge_a: assert property (!$past(i_rst) |-> o_cycle_start == $fell(i_addr_strobe_n))
    else $error("cycle start not tied to strobe fall");
  decode_hold_a: assert property (!$past(i_rst) && !$past(o_cycle_start) |-> $stable(o_decode))
    else $error("decode changed without cycle start");
  dec_lanes_a: assert property (o_cycle_start |=> o_decode.lanes == ~$past(i_cpu_byte_enables_n))
    else $error("decoded lanes wrong");
  mem_class_a: assert property (o_cycle_start && i_m_io && i_d_c
    |=> o_decode.cyc == ($past(i_w_r) ? dram_map_pkg::CYC_MEM_WR : dram_map_pkg::CYC_MEM_RD))
    else $error("memory cycle class wrong");
  npx_sel_a: assert property (o_cycle_start && !i_hold_ack_in && i_a31 && i_a29 && i_m_io
    && (i_d_c || !i_w_r) |=> o_decode.tgt == dram_map_pkg::TGT_NPX && o_decode.npx_b == $past(i_addr[25]))
    else $error("coprocessor select wrong");
  hold_mask_a: assert property (o_cycle_start && i_hold_ack_in && i_m_io
    |=> !(o_decode.tgt inside {dram_map_pkg::TGT_BIOS, dram_map_pkg::TGT_NPX}))
    else $error("upper bits not masked under hold");
  above_64m_a: assert property (o_cycle_start && !i_hold_ack_in && i_m_io && i_a26 && !i_a31
    |=> o_decode.tgt == dram_map_pkg::TGT_SLOT)
    else $error("access above 64M not sent to slot");
endmodule : dram_map_check

bind dram_memory_map_control dram_map_check dram_map_check_inst (.*);

// >>> test/test_dram_memory_map_control.sv
// Purpose: Self-checking bench for the memory map and refresh block
// Assumes: Register port and bus model driven after rising edges
// Notes: Refresh dividers are programmed small to keep the run short
`timescale 1ns/1ps
`include "dram_map_defines.svh"
module test_dram_memory_map_control;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [3:0] row_in = 4'h0;
  logic [3:0] col_in = 4'h0;
  logic [15:0] rdata;
  logic [3:0] row_n;
  logic [3:0] col_out;
  logic [3:0] be_n;
  logic [2:0] hi;
  logic [2:0] mdw;
  logic [25:2] addr;
  logic ads_n;
  logic hold;
  logic slot_req;
  logic rom16;
  dram_map_pkg::decode_t dec;
  int num_errors = 0;
  int total_checks = 0;
  int ems_id [6] = '{24, 35, 24, 32, 36, 23};
  logic [15:0] ems_ctrl [6] = '{16'h0012, 16'h0012, 16'h0016, 16'h0016, 16'h001A, 16'h0012};
  logic [19:0] ems_base [6] = '{20'hC0000, 20'hEC000, 20'hA0000, 20'hD0000, 20'h40000, 20'h9C000};

  dram_memory_map_control dram_memory_map_control_inst (.i_clk(i_clk), .i_rst(i_rst), .i_reg_addr(reg_addr),
    .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .o_reg_rdata(rdata), .i_a31(hi[2]),
    .i_a29(hi[1]), .i_a26(hi[0]), .i_addr(addr), .i_cpu_byte_enables_n(be_n), .i_w_r(mdw[0]), .i_d_c(mdw[1]),
    .i_m_io(mdw[2]), .i_addr_strobe_n(ads_n), .i_hold_ack_in(hold), .i_internal_row_strobe(row_in),
    .i_internal_col_strobe(col_in), .o_bank_row_strobe_out_n(row_n), .o_bank_col_strobe_out(col_out),
    .o_local_byte_lane_out(), .o_cycle_start(), .o_decode(dec), .o_slot_refresh_req(slot_req), .o_rom16(rom16));
  cpu_bus_model cpu_bus_model_inst (.i_clk(i_clk), .o_ads_n(ads_n), .o_hi(hi), .o_addr(addr), .o_be_n(be_n),
    .o_mdw(mdw), .o_hold(hold));

  // Clock
  initial begin
    forever #5 i_clk = ~i_clk;
  end

  // Compare, count, report
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR %s expected %0h seen %0h", n, e, s);
    end
  endtask : chk

  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim

  // Register port cycles
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge i_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge i_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge i_clk);
    reg_rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd

  // Reference cycle classes from the definition inputs
  function automatic dram_map_pkg::cycle_t cls(input logic [2:0] c);
    case (c)
      3'b000: return dram_map_pkg::CYC_INTA;
      3'b010: return dram_map_pkg::CYC_IO_RD;
      3'b011: return dram_map_pkg::CYC_IO_WR;
      3'b100: return dram_map_pkg::CYC_CODE_RD;
      3'b101: return dram_map_pkg::CYC_HALT;
      3'b110: return dram_map_pkg::CYC_MEM_RD;
      3'b111: return dram_map_pkg::CYC_MEM_WR;
      default: return dram_map_pkg::CYC_NONE;
    endcase
  endfunction : cls

  // One processor cycle against the reference decode
  task automatic bus(input logic [2:0] h, input logic [25:2] a, input logic [2:0] c, input logic hd,
    input dram_map_pkg::target_t et, input logic [25:2] ep);
    logic [3:0] b;
    b = 4'($urandom);
    cpu_bus_model_inst.run(h, a, b, c, hd);
    chk("lanes", dec.lanes, 4'(~b));
    chk("class", dec.cyc, cls(c));
    if (c[2] && c[1:0] != 2'b01) chk("target", dec.tgt, et);
    if (c[2] && c[1:0] != 2'b01 && et == dram_map_pkg::TGT_DRAM) chk("phys", dec.phys, ep);
  endtask : bus

  // Measure refresh strobe spacing and slot request intervals
  task automatic refr(input int pob, input int psb);
    int lf [5];
    int n [5];
    logic [3:0] pr;
    pr = 4'hF;
    for (int t = 0; t < 1700; t++) begin
      @(posedge i_clk);
      #1;
      for (int b = 0; b < 4; b++) begin
        if (pr[b] && !row_n[b]) begin
          if (b > 0 && n[b - 1] == n[b] + 1) chk("stagger", t - lf[b - 1], `STAGGER_CYC);
          if (n[b] > 1) chk("ob interval", t - lf[b], pob);
          lf[b] = t;
          n[b]++;
        end
      end
      if (slot_req) begin
        if (n[4] > 1) chk("slot interval", t - lf[4], psb);
        lf[4] = t;
        n[4]++;
      end
      pr = row_n;
    end
    chk("refresh seen", n[0] > 4 && n[4] > 4, 1'b1);
    $display("test refresh done");
  endtask : refr

  // Main sequence
  initial begin
    logic [15:0] v;
    logic [7:0] m;
    logic [3:0] e;
    logic [11:0] pg;
    logic [25:2] a;
    logic [2:0] h;
    logic [1:0] q [4];
    logic hd;
    logic dr;
    dram_map_pkg::target_t et;
    int j;
    void'($urandom(32'hA43EB7E7));
    repeat (16) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    #1;
    chk("row idle", row_n, 4'hF);
    chk("col idle", col_out, 4'h0);
    chk("rom width", rom16, 1'b1);
    rd(`REG_CTRL, v);
    chk("ctrl reset", v, `CTRL_RESET);
    rd(`REG_OB_DIV, v);
    chk("ob reset", v, 16'h05DC);
    rd(8'h30, v);
    chk("unmapped", v, 16'h0000);
    $display("test reset done");
    for (int t = 0; t < 5; t++) begin
      q = '{2'h0, 2'h1, 2'h2, 2'h3};
      for (int i = 3; i > 0; i--) begin
        j = $urandom % (i + 1);
        {q[i], q[j]} = {q[j], q[i]};
      end
      m = (t == 4) ? 8'h00 : {q[3], q[2], q[1], q[0]};
      wr(`REG_REMAP, {8'h00, m});
      if (t == 4) m = `REMAP_RESET;
      for (int lb = 0; lb < 4; lb++) begin
        @(posedge i_clk);
        col_in <= 4'(1 << lb);
        row_in <= 4'(1 << lb);
        repeat (2) @(posedge i_clk);
        #1;
        for (int p = 0; p < 4; p++) e[p] = (m[2 * p +: 2] == lb);
        chk("col map", col_out, e);
        chk("row map", row_n, 4'(~e));
      end
    end
    @(posedge i_clk);
    col_in <= 4'h0;
    row_in <= 4'h0;
    $display("test remap done");
    for (int k = 0; k < 6; k++) begin
      pg = 12'($urandom);
      a = {6'h00, ems_base[k][19:2]} | 24'($urandom % 4096);
      wr(`REG_CTRL, ems_ctrl[k]);
      wr(`REG_PAGE_BASE + 8'(ems_id[k]), 16'h1000 | 16'(pg));
      bus(3'h0, a, 3'b110, 1'b0, dram_map_pkg::TGT_DRAM, {pg, a[13:2]});
    end
    $display("test page map done");
    wr(`REG_CTRL, 16'h0000);
    #1;
    chk("rom width", rom16, 1'b0);
    for (int k = 0; k < 8; k++) begin
      wr(k[0] ? `REG_SHADOW_TOP : `REG_SHADOW_HI, 16'((k % 4) << (k[0] ? 8 : 0)));
      a = k[0] ? 24'h03C000 : 24'h030000;
      dr = (k % 4 == 1) || (k % 4 == (k < 4 ? 2 : 3));
      et = dr ? dram_map_pkg::TGT_DRAM : dram_map_pkg::TGT_SLOT;
      bus(3'h0, a, {2'b11, k >= 4}, 1'b0, et, a);
    end
    wr(`REG_DRAM_LIMIT, 16'h0001);
    bus(3'h0, 24'h040000, 3'b110, 1'b0, dram_map_pkg::TGT_SLOT, 24'h000000);
    wr(`REG_DRAM_LIMIT, 16'h0000);
    $display("test shadow done");
    for (int i = 0; i < 24; i++) begin
      h = 3'($urandom);
      hd = 1'($urandom);
      a = 24'($urandom) | 24'h040000;
      e = {1'b0, hd ? 3'h0 : h};
      et = e[2] ? (e[1] ? dram_map_pkg::TGT_NPX : dram_map_pkg::TGT_BIOS) : dram_map_pkg::TGT_DRAM;
      if (!e[2] && e[0]) et = dram_map_pkg::TGT_SLOT;
      bus(h, a, 3'($urandom), hd, et, a);
    end
    $display("test decode done");
    wr(`REG_OB_DIV, 16'h0014);
    wr(`REG_SB_DIV, 16'h001E);
    refr(21, 31);
    wr(`REG_CTRL, 16'h0001);
    refr(21, 21);
    end_sim();
  end

  // Watchdog against a hung run
  initial begin
    repeat (12000) @(posedge i_clk);
    num_errors++;
    end_sim();
  end
endmodule : test_dram_memory_map_control
